// File: src/arc_pkg.sv
/*
 Constants for the converter result, compare and configuration registers.
 Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
*/
package arc_pkg;
    localparam int ARC_AW = 5;
    localparam logic [4:0] ARC_OFF_RES_HI = 5'h00;
    localparam logic [4:0] ARC_OFF_RES_LO = 5'h04;
    localparam logic [4:0] ARC_OFF_CMP_HI = 5'h08;
    localparam logic [4:0] ARC_OFF_CMP_LO = 5'h0c;
    localparam logic [4:0] ARC_OFF_CFG = 5'h10;
    localparam logic [4:0] ARC_OFF_PIN = 5'h14;
    localparam logic [4:0] ARC_OFF_STAT = 5'h18;
    localparam int ARC_CFG_LPC = 7;
    localparam int ARC_CFG_DIV = 5;
    localparam int ARC_CFG_SMP = 4;
    localparam int ARC_CFG_MODE = 2;
    localparam int ARC_CFG_CLK = 0;
    localparam int ARC_ST_CONVERSION_COMPLETE_FLAG = 7;
    localparam int ARC_ST_CMPEN = 5;
    localparam int ARC_ST_GT = 4;
    localparam logic [7:0] ARC_CFG_RST = 8'h00;
    localparam logic [7:0] ARC_PIN_RST = 8'h00;
    localparam logic [7:0] ARC_CMP_RST = 8'h00;
    localparam logic [11:0] ARC_RES_RST = 12'h000;
    localparam logic [11:0] ARC_MASK_8 = 12'h0ff;
    localparam logic [11:0] ARC_MASK_10 = 12'h3ff;
    localparam logic [11:0] ARC_MASK_12 = 12'hfff;
    localparam logic [11:0] ARC_ONE = 12'h001;
    localparam logic [1:0] ARC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ARC_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ARC_MODE_8 = 2'h0,
        ARC_MODE_12 = 2'h1,
        ARC_MODE_10 = 2'h2,
        ARC_MODE_RSV = 2'h3
    } arc_mode_t;
endpackage

// File: src/arc_adc_regs.sv
/*
 Register side of a successive approximation converter: result capture,
 high/low read interlock, automatic compare, configuration and pin control.
 Assumes the converter core pulses i_conv_done for one cycle with the raw
 result, right aligned to the active resolution, on i_conv_result.
// Function
// - High result byte holds result bits 11:8 (12-bit) or 9:8 (10-bit)
// - Result bits 11:10 read zero in 10-bit, 11:8 in 8-bit mode
// - Results load every completion unless compare enabled and condition fails
// - On compare event store result plus two's complement of compare value
// - In 12/10-bit mode high byte read blocks transfers until low byte read
// - Conversion completing while blocked is discarded
// - In 8-bit mode high byte read does not block transfers
// - Changing resolution mode invalidates both result bytes
// - Low result byte holds bits 7:0, or whole 8-bit result
// - Compare high holds bits 11:8 or 9:8, checked against upper result bits
// - In 8-bit mode compare ignores the compare high register
// - Compare value bits 7:0 checked against result bits 7:0 in every mode
// - Configuration bit 7 selects high speed (0) or low power (1)
// - Configuration bits 6:5 divide input clock by 1, 2, 4 or 8
// - Configuration bit 4 selects short (0) or long (1) sample time
// - Configuration bits 3:2 select 8, 12, 10-bit; 11 reserved
// - Configuration bits 1:0 select bus, bus/2, alternate or async clock
// - Pin disable bit n governs channel n pin 0-7, reset 0
// - Completion flag clears on status write or low result byte read
// - Compare true on result below value, or at/above when greater enabled
// - Set pin bit forces high impedance, no pullup, no input; reads zero
*/
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module arc_adc_regs
    import arc_pkg::*;
#(
    parameter int ADDR_W = 32
)(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_conv_done,
    input wire logic [11:0] i_conv_result,
    input wire logic [7:0] i_port_pin,
    output logic o_low_power,
    output logic [1:0] o_clk_div,
    output logic o_long_sample,
    output logic [1:0] o_mode,
    output logic [1:0] o_clk_sel,
    output logic [7:0] o_pin_disable,
    output logic [7:0] o_port_read,
    output logic o_conv_complete
);

    function automatic logic [11:0] res_mask(input logic [1:0] mode);
        case (mode)
            ARC_MODE_8: res_mask = ARC_MASK_8;
            ARC_MODE_10: res_mask = ARC_MASK_10;
            default: res_mask = ARC_MASK_12;
        endcase
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [ARC_AW-1:0] o;
        o = a[ARC_AW-1:0];
        mapped = (o == ARC_OFF_RES_HI) || (o == ARC_OFF_RES_LO) ||
            (o == ARC_OFF_CMP_HI) || (o == ARC_OFF_CMP_LO) ||
            (o == ARC_OFF_CFG) || (o == ARC_OFF_PIN) || (o == ARC_OFF_STAT);
    endfunction

    logic awready_q;
    logic wready_q;
    logic aw_full_q;
    logic w_full_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [7:0] wdata_q;
    logic wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [11:0] res_q;
    logic lock_q;
    logic conversion_complete_flag_q;
    logic cmpen_q;
    logic gt_q;
    logic [7:0] cvh_q;
    logic [7:0] cvl_q;
    logic [7:0] cfg_q;
    logic [7:0] pin_q;
    logic [7:0] port_q;
    logic wr_go;
    logic rd_go;
    logic [ARC_AW-1:0] woff;
    logic [ARC_AW-1:0] roff;
    logic wr_en;
    logic cfg_wr;
    logic stat_wr;
    logic mode_chg;
    logic rd_hi;
    logic rd_lo;
    logic [1:0] mode;
    logic [11:0] mask;
    logic [11:0] res;
    logic [11:0] cv;
    logic [11:0] diff;
    logic cond;
    logic accept;
    logic load;
    assign wr_go = aw_full_q && w_full_q && !bvalid_q;
    assign woff = waddr_q[ARC_AW-1:0];
    assign wr_en = wr_go && wstrb_q;
    assign cfg_wr = wr_en && (woff == ARC_OFF_CFG);
    assign stat_wr = wr_en && (woff == ARC_OFF_STAT);
    assign mode = cfg_q[ARC_CFG_MODE+:2];
    assign mode_chg = cfg_wr && (wdata_q[ARC_CFG_MODE+:2] != mode);
    assign rd_go = i_arvalid && arready_q;
    assign roff = i_araddr[ARC_AW-1:0];
    assign rd_hi = rd_go && (roff == ARC_OFF_RES_HI);
    assign rd_lo = rd_go && (roff == ARC_OFF_RES_LO);

    // Compare value is masked, so 8-bit mode never sees the high byte
    assign mask = res_mask(mode);
    assign res = i_conv_result & mask;
    assign cv = {cvh_q[3:0], cvl_q} & mask;
    assign cond = gt_q ? (res >= cv) : (res < cv);
    assign diff = (res + ~cv + ARC_ONE) & mask;
    assign accept = i_conv_done && (!cmpen_q || cond);
    assign load = accept && !lock_q;

    // Write address and data are taken independently, in either order
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            awready_q <= 1'b1;
            aw_full_q <= 1'b0;
            waddr_q <= '0;
        end
        else if (i_awvalid && awready_q)
        begin
            awready_q <= 1'b0;
            aw_full_q <= 1'b1;
            waddr_q <= i_awaddr;
        end
        else if (wr_go)
        begin
            aw_full_q <= 1'b0;
        end
        else if (bvalid_q && i_bready)
        begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            wready_q <= 1'b1;
            w_full_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= 1'b0;
        end
        else if (i_wvalid && wready_q)
        begin
            wready_q <= 1'b0;
            w_full_q <= 1'b1;
            wdata_q <= i_wdata[7:0];
            wstrb_q <= i_wstrb[0];
        end
        else if (wr_go)
        begin
            w_full_q <= 1'b0;
        end
        else if (bvalid_q && i_bready)
        begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= ARC_RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= mapped(waddr_q) ? ARC_RESP_OKAY : ARC_RESP_SLVERR;
        end
        else if (bvalid_q && i_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // Writable registers; lane 0 carries all eight bits
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cvh_q <= ARC_CMP_RST;
            cvl_q <= ARC_CMP_RST;
            cfg_q <= ARC_CFG_RST;
            pin_q <= ARC_PIN_RST;
            cmpen_q <= 1'b0;
            gt_q <= 1'b0;
        end
        else if (wr_en)
        begin
            case (woff)
                ARC_OFF_CMP_HI: cvh_q <= wdata_q;
                ARC_OFF_CMP_LO: cvl_q <= wdata_q;
                ARC_OFF_CFG: cfg_q <= wdata_q;
                ARC_OFF_PIN: pin_q <= wdata_q;
                ARC_OFF_STAT:
                begin
                    cmpen_q <= wdata_q[ARC_ST_CMPEN];
                    gt_q <= wdata_q[ARC_ST_GT];
                end
                default: ;
            endcase
        end
    end

    // A result dropped while blocked never raises the flag
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            conversion_complete_flag_q <= 1'b0;
        end
        else if (load)
        begin
            conversion_complete_flag_q <= 1'b1;
        end
        else if (stat_wr || rd_lo)
        begin
            conversion_complete_flag_q <= 1'b0;
        end
    end

    // Mode change wipes stale data rather than leaving mixed-width bits
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            res_q <= ARC_RES_RST;
        end
        else if (mode_chg)
        begin
            res_q <= ARC_RES_RST;
        end
        else if (load)
        begin
            res_q <= cmpen_q ? diff : res;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            lock_q <= 1'b0;
        end
        else if (rd_lo || mode_chg)
        begin
            lock_q <= 1'b0;
        end
        else if (rd_hi && (mode == ARC_MODE_12 || mode == ARC_MODE_10))
        begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= ARC_RESP_OKAY;
        end
        else if (rd_go)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= mapped(i_araddr) ? ARC_RESP_OKAY : ARC_RESP_SLVERR;
            case (roff)
                ARC_OFF_RES_HI: rdata_q <= {28'h0, res_q[11:8]};
                ARC_OFF_RES_LO: rdata_q <= {24'h0, res_q[7:0]};
                ARC_OFF_CMP_HI: rdata_q <= {24'h0, cvh_q};
                ARC_OFF_CMP_LO: rdata_q <= {24'h0, cvl_q};
                ARC_OFF_CFG: rdata_q <= {24'h0, cfg_q};
                ARC_OFF_PIN: rdata_q <= {24'h0, pin_q};
                ARC_OFF_STAT: rdata_q <= {24'h0, conversion_complete_flag_q, 1'b0, cmpen_q, gt_q, 4'h0};
                default: rdata_q <= '0;
            endcase
        end
        else if (rvalid_q && i_rready)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // Port read of a disabled pin returns zero
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            port_q <= '0;
        end
        else
        begin
            port_q <= i_port_pin & ~pin_q;
        end
    end

    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_low_power = cfg_q[ARC_CFG_LPC];
    assign o_clk_div = cfg_q[ARC_CFG_DIV+:2];
    assign o_long_sample = cfg_q[ARC_CFG_SMP];
    assign o_mode = cfg_q[ARC_CFG_MODE+:2];
    assign o_clk_sel = cfg_q[ARC_CFG_CLK+:2];
    assign o_pin_disable = pin_q;
    assign o_port_read = port_q;
    assign o_conv_complete = conversion_complete_flag_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_hi_read_wide;
        rd_hi && (mode == ARC_MODE_12 || mode == ARC_MODE_10) && !rd_lo && !mode_chg;
    endsequence
    sequence s_blocked_done;
        lock_q && i_conv_done && !mode_chg;
    endsequence
    AST_HI_READ_LOCKS: assert property (s_hi_read_wide ##1 !rd_lo [*1]
        |-> lock_q)
        else $error("high byte read did not block transfers");
    AST_BLOCKED_DROP: assert property (s_blocked_done |=>
        $stable(res_q) && !$rose(conversion_complete_flag_q))
        else $error("result changed while transfer blocked");
    AST_NO_LOCK_8: assert property (rd_hi && mode == ARC_MODE_8 && !lock_q
        |=> !lock_q)
        else $error("8-bit high byte read set the interlock");
    AST_CMP_FAIL_KEEP: assert property (i_conv_done && cmpen_q && !cond &&
        !mode_chg |=> $stable(res_q))
        else $error("failed compare updated result");
    AST_DIFF_STORE: assert property (load && cmpen_q && !mode_chg |=>
        res_q == (($past(i_conv_result) & $past(mask)) +
        ~($past(cv)) + ARC_ONE & $past(mask)))
        else $error("compare difference stored wrongly");
    AST_UPPER_ZERO: assert property (mode == ARC_MODE_8 && !cfg_wr
        |=> res_q[11:8] == 4'h0)
        else $error("unused high result bits not zero in 8-bit mode");
    AST_MODE_WIPE: assert property (mode_chg |=> res_q == ARC_RES_RST
        && !lock_q)
        else $error("mode change left result data");
    AST_FLAG_CLEAR: assert property (rd_lo && !load |=> !conversion_complete_flag_q && rvalid_q &&
        rdata_q[7:0] == $past(res_q[7:0]))
        else $error("low byte read did not clear flag");
    AST_PIN_ZERO: assert property (##1 (o_port_read & $past(pin_q)) == 8'h00)
        else $error("disabled pin read returned one");

endmodule // arc_adc_regs
`default_nettype wire

// File: testbench/arc_core_model.sv
/*
 Behavioural converter core: a start request returns the sample, cut to
 the active resolution, as a one-cycle completion pulse LAT cycles later.
 Assumes one clock shared with the register block and its o_mode output.
*/
`timescale 1ns/1ps
`default_nettype none
module arc_core_model
    import arc_pkg::*;
#(
    parameter int LAT = 3
)(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [11:0] i_sample,
    input wire logic [1:0] i_mode,
    output logic o_done,
    output logic [11:0] o_result
);
    logic [3:0] cnt_q;
    logic [11:0] smp_q;
    logic [11:0] mask;
    always_ff @(posedge i_clk)
    begin
        o_done <= 1'b0;
        if (!i_rst_n)
            cnt_q <= 4'h0;
        else if (i_start)
        begin
            cnt_q <= 4'(LAT);
            smp_q <= i_sample;
        end
        else if (cnt_q != 4'h0)
        begin
            cnt_q <= cnt_q - 4'h1;
            o_done <= (cnt_q == 4'h1);
        end
    end
    assign mask = (i_mode == ARC_MODE_8) ? ARC_MASK_8 :
        (i_mode == ARC_MODE_10) ? ARC_MASK_10 : ARC_MASK_12;
    // Outside the pulse the bus shows junk, so a stale value never passes
    assign o_result = o_done ? (smp_q & mask) : ~smp_q;
endmodule // arc_core_model
`default_nettype wire

// File: testbench/adc_result_compare_config_tb_top.sv
/*
 Self-checking bench: AXI4-Lite register tasks and converter requests.
 Assumes the core model above and the register offsets of arc_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_result_compare_config_tb_top
    import arc_pkg::*;
;
    logic i_clk, rst_n, awv, wv, bready, arv, rready, start, done;
    logic awr, wrd, bv, arr, rv, lpc, lsmp, cc;
    logic [1:0] bresp, rresp, div, mode, csel, resp, k;
    logic [31:0] awaddr, araddr, wdata, rdata;
    logic [11:0] smp, res;
    logic [7:0] pin, rdv, pdis, pread;
    int n_fail, checked;

    arc_adc_regs #(.ADDR_W(32)) uut (.i_clk(i_clk), .i_rst_n(rst_n),
        .i_awvalid(awv), .o_awready(awr), .i_awaddr(awaddr), .i_awprot(3'h0),
        .i_wvalid(wv), .o_wready(wrd), .i_wdata(wdata), .i_wstrb(4'h1),
        .o_bvalid(bv), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arv), .o_arready(arr), .i_araddr(araddr), .i_arprot(3'h0),
        .o_rvalid(rv), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_conv_done(done), .i_conv_result(res), .i_port_pin(pin),
        .o_low_power(lpc), .o_clk_div(div), .o_long_sample(lsmp), .o_mode(mode),
        .o_clk_sel(csel), .o_pin_disable(pdis), .o_port_read(pread),
        .o_conv_complete(cc));
    arc_core_model #(.LAT(3)) core (.i_clk(i_clk), .i_rst_n(rst_n),
        .i_start(start), .i_sample(smp), .i_mode(mode), .o_done(done),
        .o_result(res));

    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 40)
        begin
            n_fail++;
            summarize();
        end
    endtask

    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask

    // Address and data are released separately, whichever is taken first
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        awaddr <= {27'h0, a};
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
        end while (!bv && n < 40);
        resp = bresp;
        tmo(n);
    endtask

    task automatic rd(input logic [4:0] a);
        int n;
        n = 0;
        araddr <= {27'h0, a};
        arv <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
            if (arv && arr) arv <= 1'b0;
        end while (!rv && n < 40);
        rdv = rdata[7:0];
        resp = rresp;
        tmo(n);
    endtask

    task automatic rc(input string s, input logic [4:0] a, input logic [7:0] e);
        rd(a);
        chk(s, e, rdv);
    endtask

    // Returns at the edge that hands the result to the register block
    task automatic cv(input logic [11:0] v);
        int n;
        n = 0;
        smp <= v;
        start <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
        do
        begin
            @(posedge i_clk);
            n++;
        end while (!done && n < 40);
        tmo(n);
    endtask

    initial
    begin
        {awv, wv, bready, arv, rready, start, rst_n} = 7'h00;
        {awaddr, araddr, wdata} = 96'h0;
        smp = 12'h000;
        pin = 8'hff;
        n_fail = 0;
        checked = 0;
        repeat (12) @(posedge i_clk);
        rst_n <= 1'b1;
        @(posedge i_clk);
        rc("cfg", ARC_OFF_CFG, ARC_CFG_RST);
        chk("rresp", {6'h0, ARC_RESP_OKAY}, {6'h0, resp});
        rc("pin", ARC_OFF_PIN, ARC_PIN_RST);
        rc("cvh", ARC_OFF_CMP_HI, ARC_CMP_RST);
        rc("cvl", ARC_OFF_CMP_LO, ARC_CMP_RST);
        rc("bad", 5'h1c, 8'h00);
        chk("rresp", {6'h0, ARC_RESP_SLVERR}, {6'h0, resp});
        wr(5'h1c, 8'h00);
        chk("bresp", {6'h0, ARC_RESP_SLVERR}, {6'h0, resp});
        for (int c = 0; c < 4; c++)
        begin
            k = 2'(c);
            wr(ARC_OFF_CFG, {k[0], k, k[1], k, k});
            rc("cfgrb", ARC_OFF_CFG, {k[0], k, k[1], k, k});
            chk("lpc", {7'h0, k[0]}, {7'h0, lpc});
            chk("div", {6'h0, k}, {6'h0, div});
            chk("smp", {7'h0, k[1]}, {7'h0, lsmp});
            chk("mode", {6'h0, k}, {6'h0, mode});
            chk("csel", {6'h0, k}, {6'h0, csel});
        end
        wr(ARC_OFF_PIN, 8'ha5);
        chk("bresp", {6'h0, ARC_RESP_OKAY}, {6'h0, resp});
        rc("pinrb", ARC_OFF_PIN, 8'ha5);
        chk("pdis", 8'ha5, pdis);
        chk("pread", 8'h5a, pread);
        wr(ARC_OFF_CFG, 8'h04);
        cv(12'habc);
        rc("st", ARC_OFF_STAT, 8'h80);
        chk("cc", 8'h01, {7'h0, cc});
        rc("hi12", ARC_OFF_RES_HI, 8'h0a);
        rc("lo12", ARC_OFF_RES_LO, 8'hbc);
        chk("cc", 8'h00, {7'h0, cc});
        rc("st", ARC_OFF_STAT, 8'h00);
        cv(12'h123);
        rc("hi", ARC_OFF_RES_HI, 8'h01);
        cv(12'h456);
        rc("lock", ARC_OFF_RES_LO, 8'h23);
        rc("st", ARC_OFF_STAT, 8'h00);
        cv(12'h789);
        rc("st2", ARC_OFF_STAT, 8'h80);
        wr(ARC_OFF_STAT, 8'h00);
        rc("stw", ARC_OFF_STAT, 8'h00);
        rc("free", ARC_OFF_RES_LO, 8'h89);
        wr(ARC_OFF_CFG, 8'h08);
        rc("mchi", ARC_OFF_RES_HI, 8'h00);
        rc("mclo", ARC_OFF_RES_LO, 8'h00);
        wr(ARC_OFF_CMP_HI, 8'h02);
        wr(ARC_OFF_CMP_LO, 8'h10);
        wr(ARC_OFF_STAT, 8'h20);
        cv(12'h205);
        rc("dhi", ARC_OFF_RES_HI, 8'h03);
        rc("dlo", ARC_OFF_RES_LO, 8'hf5);
        cv(12'h3f0);
        rc("keep", ARC_OFF_RES_LO, 8'hf5);
        wr(ARC_OFF_CFG, 8'h00);
        wr(ARC_OFF_STAT, 8'h30);
        wr(ARC_OFF_CMP_HI, 8'h0f);
        wr(ARC_OFF_CMP_LO, 8'h80);
        cv(12'h010);
        rc("st8", ARC_OFF_STAT, 8'h30);
        cv(12'h090);
        rc("hi8", ARC_OFF_RES_HI, 8'h00);
        cv(12'h0c5);
        rc("lo8", ARC_OFF_RES_LO, 8'h45);
        wr(ARC_OFF_CFG, 8'h04);
        wr(ARC_OFF_CMP_HI, 8'h0a);
        wr(ARC_OFF_CMP_LO, 8'h00);
        cv(12'habc);
        rc("chi", ARC_OFF_RES_HI, 8'h00);
        rc("clo", ARC_OFF_RES_LO, 8'hbc);
        summarize();
    end
endmodule // adc_result_compare_config_tb_top
`default_nettype wire
